// ---- src/comparator_output_debounce.sv ----
// Comparator output conditioning: inversion, debounce, control register.
// Assumes a raw asynchronous comparator decision and a same-clock CPU port.
//
// Notes on behaviour
// - Select 000 passes result without debounce
// - Selects 001-011 need 3-4, 7-8, 15-16 ticks
// - Selects 100-111 need 31-32 up to 255-256
// - Filtered result readable at bit 4, read-only
// - Bit 3 inverts decision before the filter
// - Status polarity follows inversion setting
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module comparator_output_debounce (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output var  logic [7:0] reg_rdata_out,
  input  wire logic       compare_raw_in,
  output var  logic       comparator_power_enable_out,
  output var  logic [1:0] hysteresis_select_out,
  output var  logic       filtered_compare_result_out
);
  cmp_debounce_pkg::ctrl_fields_t ctrl_reg;
  cmp_debounce_pkg::ctrl_fields_t ctrl_next;
  cmp_debounce_pkg::reg_request_t req;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       raw_sync;
  logic       sample;
  logic       filtered_compare_result;
  logic [7:0] ctrl_view;

  assign req = '{write_strobe: reg_write_in, read_strobe: reg_read_in,
                 address: reg_addr_in, write_data: reg_wdata_in};

  sync_two_flop u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (compare_raw_in),
    .sync_out   (raw_sync)
  );

  // Invert ahead of the filter so the status bit carries the chosen polarity
  assign sample = raw_sync ^ ctrl_reg.invert;

  stability_filter #(
    .CW (cmp_debounce_pkg::CNT_WIDTH)
  ) u_filter (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (ctrl_reg.power_enable),
    .tick_in      (1'b1),
    .sample_in    (sample),
    .select_in    (ctrl_reg.length_select),
    .filtered_out (filtered_compare_result)
  );

  // Result bit is slotted in from the filter, never from stored write data
  assign ctrl_view = {ctrl_reg.power_enable, ctrl_reg.hysteresis,
                      filtered_compare_result, ctrl_reg.invert,
                      ctrl_reg.length_select};

  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = 8'h00;
    if (req.write_strobe && req.address == cmp_debounce_pkg::CTRL_OFFSET) begin
      ctrl_next.power_enable  = req.write_data[cmp_debounce_pkg::ENABLE_BIT];
      ctrl_next.hysteresis    = req.write_data[cmp_debounce_pkg::HYST_HI_BIT:
                                               cmp_debounce_pkg::HYST_LO_BIT];
      ctrl_next.invert        = req.write_data[cmp_debounce_pkg::INVERT_BIT];
      ctrl_next.length_select = req.write_data[cmp_debounce_pkg::DEB_SEL_HI:
                                               cmp_debounce_pkg::DEB_SEL_LO];
    end
    if (req.read_strobe) begin
      if (req.address == cmp_debounce_pkg::CTRL_OFFSET) begin
        rdata_next = ctrl_view;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg  <= cmp_debounce_pkg::ctrl_fields_t'(7'h00);
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out               = rdata_reg;
  assign comparator_power_enable_out = ctrl_reg.power_enable;
  assign hysteresis_select_out       = ctrl_reg.hysteresis;
  assign filtered_compare_result_out = filtered_compare_result;
endmodule
`default_nettype wire

// ---- src/cmp_debounce_pkg.sv ----
// Package for the comparator output conditioning stage.
// Assumes one system clock; used by the top and filter design files as package::name.
package cmp_debounce_pkg;

  localparam int unsigned CTRL_WIDTH       = 8;
  localparam logic [0:0]  CTRL_OFFSET      = 1'h0;
  localparam int unsigned ENABLE_BIT       = 7;
  localparam int unsigned HYST_HI_BIT      = 6;
  localparam int unsigned HYST_LO_BIT      = 5;
  localparam int unsigned RESULT_BIT       = 4;
  localparam int unsigned INVERT_BIT       = 3;
  localparam int unsigned DEB_SEL_HI       = 2;
  localparam int unsigned DEB_SEL_LO       = 0;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  CTRL_WRITE_MASK  = 8'hef;

  localparam int unsigned SEL_WIDTH        = 3;
  localparam logic [2:0]  SEL_BYPASS       = 3'h0;
  localparam int unsigned CNT_WIDTH        = 8;

  // Debounce tick is one system clock period
  localparam int unsigned CLK_FREQ_MHZ     = 50;
  localparam int unsigned TICK_PERIOD_NS   = 20;
  localparam int unsigned TICK_CYCLES      = (TICK_PERIOD_NS * CLK_FREQ_MHZ + 999) / 1000;

  typedef struct packed {
    logic       power_enable;
    logic [1:0] hysteresis;
    logic       invert;
    logic [2:0] length_select;
  } ctrl_fields_t;

  typedef struct packed {
    logic       write_strobe;
    logic       read_strobe;
    logic [0:0] address;
    logic [7:0] write_data;
  } reg_request_t;

endpackage

// ---- src/sync_two_flop.sv ----
// Two flip-flop synchroniser for the raw comparator decision.
// Assumes the input is asynchronous to clock_in.
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop (
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule
`default_nettype wire

// ---- src/stability_filter.sv ----
// Debounce counter: output follows the input once it has been stable for the
// selected number of ticks. Assumes tick_in is a one-cycle enable pulse.
`timescale 1ns/1ns
`default_nettype none
module stability_filter #(
  parameter int unsigned CW = cmp_debounce_pkg::CNT_WIDTH
) (
  input  wire logic          clock_in,
  input  wire logic          sys_rst_in,
  input  wire logic          run_in,
  input  wire logic          tick_in,
  input  wire logic          sample_in,
  input  wire logic [2:0]    select_in,
  output var  logic          filtered_out
);
  logic          out_reg;
  logic          out_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CW-1:0] limit;

  // Select n needs 2^(n+1)-1 stable ticks; sample phase adds up to one more
  assign limit = CW'((9'h002 << select_in) - 9'h002);

  always_comb begin
    out_next = out_reg;
    cnt_next = cnt_reg;
    if (!run_in) begin
      cnt_next = '0;
    end else if (select_in == cmp_debounce_pkg::SEL_BYPASS) begin
      out_next = sample_in;
      cnt_next = '0;
    end else if (sample_in == out_reg) begin
      cnt_next = '0;
    end else if (tick_in) begin
      if (cnt_reg >= limit) begin
        out_next = sample_in;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      out_reg <= out_next;
      cnt_reg <= cnt_next;
    end
  end

  assign filtered_out = out_reg;
endmodule
`default_nettype wire

// ---- bench/cmp_core_model.sv ----
// Analog comparator core model.
// Assumes the bench sets which input is higher.
`timescale 1ns/1ns
`default_nettype none
module cmp_core_model (
  input  wire logic power_in,
  input  wire logic pos_above_in,
  output var  logic decision_out
);
  // Unpowered core reads low, so enabling can step the decision
  always_comb decision_out = power_in && pos_above_in;
endmodule
`default_nettype wire

// ---- bench/cod_chk.sv ----
// Checker for the debounce stage top ports.
// Assumes the control register sits at address 0.
`timescale 1ns/1ns
`default_nettype none
module cod_chk (
  input wire logic       clock_in,
  input wire logic       sys_rst_in,
  input wire logic       reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  input wire logic       reg_read_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       compare_raw_in,
  input wire logic       comparator_power_enable_out,
  input wire logic       filtered_compare_result_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  logic [7:0] c_reg;
  logic [7:0] c_next;
  logic       f;
  assign f = filtered_compare_result_out;
  always_comb c_next = (reg_write_in && !reg_addr_in) ? reg_wdata_in : c_reg;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) c_reg <= 8'h00;
    else c_reg <= c_next;
  end
  a_power_bit: assert property (comparator_power_enable_out == c_reg[7])
    else $error("power bit");
  a_off_frozen: assert property (!c_reg[7] && !c_next[7] |=> $stable(f))
    else $error("frozen");
  a_read_value: assert property (reg_read_in && !reg_addr_in |=>
    reg_rdata_out == {$past(c_reg[7:5]), $past(f), $past(c_reg[3:0])}) else $error("read");
  a_unmapped_zero: assert property (reg_read_in && reg_addr_in |=> reg_rdata_out == 8'h00)
    else $error("unmapped");
  a_rdata_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("idle data");
  a_bypass_follow: assert property ((c_reg[7] && c_reg[2:0] == 3'h0 &&
    $stable(c_reg) && $stable(compare_raw_in))[*4] |-> f == (compare_raw_in ^ c_reg[3]))
    else $error("bypass");
  a_short_settle: assert property ((c_reg[7] && c_reg[2:0] == 3'h1 &&
    $stable(c_reg) && $stable(compare_raw_in))[*8] |-> f == (compare_raw_in ^ c_reg[3]))
    else $error("settle");
  c_bypass: cover property (c_reg[2:0] == 3'h0 && $rose(f));
  c_long: cover property (c_reg[2:0] == 3'h7 && $rose(f));
  c_unmapped: cover property (reg_read_in && reg_addr_in);
endmodule
bind comparator_output_debounce cod_chk u_cod_chk (.clock_in, .sys_rst_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .compare_raw_in,
  .comparator_power_enable_out, .filtered_compare_result_out);
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the debounce stage.
// Assumes read data stand one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic       clock_in, sys_rst_in, reg_addr_in, reg_write_in, reg_read_in, raw, pa, en, res;
  logic [7:0] reg_wdata_in, rdata;
  logic [1:0] hyst;
  int         num_errors, checked, cycles, n;
  comparator_output_debounce u_comparator_output_debounce (.clock_in, .sys_rst_in,
    .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out(rdata),
    .compare_raw_in(raw), .comparator_power_enable_out(en), .hysteresis_select_out(hyst),
    .filtered_compare_result_out(res));
  cmp_core_model u_cmp_core_model (.power_in(en), .pos_above_in(pa), .decision_out(raw));
  task automatic check(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: mismatch", $time);
    end
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic a, input logic [7:0] e);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    @(posedge clock_in);
    check(rdata === e);
  endtask
  task automatic t_lat(input logic [2:0] s);
    wr(1'b0, {5'h10, s});
    pa <= 1'b0;
    repeat (300) @(posedge clock_in);
    pa <= 1'b1;
    n = 0;
    while (res !== 1'b1 && n < 400) begin
      @(posedge clock_in);
      n++;
    end
    check(s == 0 ? n == 4 : n >= (2 << s) + 2 && n <= (2 << s) + 5);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    {sys_rst_in, reg_addr_in, reg_write_in, reg_read_in, pa} = 5'h10;
    reg_wdata_in = 8'h00;
    repeat (5) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    wr(1'b0, 8'h7f);
    rd(1'b0, 8'h6f);
    check(en === 1'b0 && hyst === 2'h3);
    wr(1'b1, 8'hff);
    rd(1'b1, 8'h00);
    wr(1'b0, 8'h81);
    repeat (20) @(posedge clock_in);
    check(en === 1'b1 && hyst === 2'h0);
    pa <= 1'b1;
    repeat (2) @(posedge clock_in);
    pa <= 1'b0;
    repeat (10) @(posedge clock_in);
    check(res === 1'b0);
    for (int s = 0; s < 8; s++) t_lat(3'(s));
    wr(1'b0, 8'h88);
    repeat (8) @(posedge clock_in);
    rd(1'b0, 8'h88);
    pa <= 1'b0;
    repeat (8) @(posedge clock_in);
    rd(1'b0, 8'h98);
    wr(1'b0, 8'h00);
    repeat (8) @(posedge clock_in);
    rd(1'b0, 8'h10);
    check(en === 1'b0);
    final_report();
  end
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
